// File: test/charge_time_edge_control_assertions.sv
// Port checker for the charge time unit, bound to its top module
`timescale 1ns/1ps
// ==========================================
// Checker module
module charge_time_edge_control_checker
   import charge_time_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic idleMode,
   input wire logic timerEvent,
   input wire logic compareOut,
   input wire logic captureEvent,
   input wire logic comparatorOut,
   input wire logic edge_pin_a,
   input wire logic edge_pin_b,
   input wire logic currentOn,
   input wire logic sourceGroundOut,
   input wire logic delayPulse,
   input wire logic triggerPulse,
   input wire logic irq
);
   logic [15:0] ctlQ;
   logic [15:0] ctlD;
   logic mapped;
   logic gnd;

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);

   // Address decode and grounding request seen from the bus
   assign mapped = paddr inside {OFFS_CONTROL_ONE, OFFS_CONTROL_TWO, OFFS_IRQ_STATUS,
      OFFS_IRQ_ENABLE, OFFS_IRQ_CLEAR};
   assign gnd = ctlQ[BIT_UNIT_ENABLE] && ctlQ[BIT_SOURCE_GROUND];

   // Shadow of control register one, taken at the access edge
   always_comb begin
      ctlD = ctlQ;
      if (psel && penable && pwrite && pready && paddr == OFFS_CONTROL_ONE) begin
         ctlD = pwdata[15:0] & CONTROL_ONE_MASK;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         ctlQ <= CONTROL_ONE_RESET;
      end else begin
         ctlQ <= ctlD;
      end
   end

   ctl_readback_a: assert property (psel && penable && !pwrite && paddr == OFFS_CONTROL_ONE
      |-> prdata == {16'h0000, ctlQ}) else $error("control one read back wrong");
   bus_error_a: assert property (psel && penable |-> pslverr == !mapped)
      else $error("slave error does not follow the address map");
   trigger_single_a: assert property (triggerPulse |=> !triggerPulse)
      else $error("trigger pulse longer than one cycle");
   trigger_gate_a: assert property (triggerPulse |-> $past(ctlQ[BIT_TRIGGER_OUT]))
      else $error("trigger pulse while trigger output disabled");
   ground_on_a: assert property ($rose(gnd) |-> ##[0:1] sourceGroundOut)
      else $error("current source not grounded");
   ground_off_a: assert property ((!gnd) [*2] |-> !sourceGroundOut)
      else $error("current source grounded without request");
   unit_off_a: assert property ((!ctlQ[BIT_UNIT_ENABLE]) [*3] |-> !currentOn && !triggerPulse)
      else $error("disabled unit still active");
   gate_block_a: assert property ((!ctlQ[BIT_EDGE_GATE]) [*3] |-> !currentOn)
      else $error("current flows while edges blocked");
   idle_halt_a: assert property ((idleMode && ctlQ[BIT_IDLE_STOP]) [*3] |-> !triggerPulse)
      else $error("unit active while stopped in idle");

   cover property (triggerPulse);
   cover property (pslverr);
   cover property ($rose(irq));
   cover property ($rose(currentOn));
endmodule

bind charge_time_edge_control charge_time_edge_control_checker i_chk (.*);

// File: test/charge_time_edge_control_bench.sv
// Self-checking bench of the charge time unit with a register model
`timescale 1ns/1ps
// ==========================================
// Bench top
module charge_time_edge_control_bench;
   import charge_time_pkg::*;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, idleMode = 1'b0;
   logic tmr, cmpo, cap, cmpr, pinA, pinB;
   logic currentOn, sourceGroundOut, delayPulse, triggerPulse, irq;
   logic [5:0] lvl = 6'h00;
   bit [15:0] exp1, exp2;
   bit [1:0] expEn, expSt;
   int fails, nTests, cycles, trigCnt, trigExp;
   int seed = 5783;

   charge_time_edge_control i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .idleMode(idleMode), .timerEvent(tmr),
      .compareOut(cmpo), .captureEvent(cap), .comparatorOut(cmpr), .edge_pin_a(pinA),
      .edge_pin_b(pinB), .currentOn(currentOn), .sourceGroundOut(sourceGroundOut),
      .delayPulse(delayPulse), .triggerPulse(triggerPulse), .irq(irq));
   edge_source_model i_src (.ref_clk(ref_clk), .lvl(lvl), .timerEvent(tmr), .compareOut(cmpo),
      .captureEvent(cap), .comparatorOut(cmpr), .edge_pin_a(pinA), .edge_pin_b(pinB));

   initial begin
      forever #10 ref_clk = ~ref_clk;
   end

   // Cycle limit and trigger pulse counter
   always @(posedge ref_clk) begin
      cycles++;
      if (triggerPulse === 1'b1) trigCnt++;
      if (cycles == 10000) begin
         fails++;
         closeOut();
      end
   end

   task automatic closeOut();
      $display("comparisons %0d mismatches %0d", nTests, fails);
      if (fails == 0 && nTests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic cmp32(input logic [31:0] g, input logic [31:0] e);
      nTests++;
      if (g !== e) begin
         fails++;
         $display("CHECK FAILED at %0t: value %h expected %h", $time, g, e);
      end
   endtask

   task automatic cmp1(input logic g, input logic e);
      nTests++;
      if (g !== e) begin
         fails++;
         $display("CHECK FAILED at %0t: flag %b expected %b", $time, g, e);
      end
   endtask

   // One APB transfer, held until pready is seen at a rising edge
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
      output logic [31:0] r);
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
      end while (pready !== 1'b1);
      r = prdata;
      cmp1(pslverr, !(a inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10}));
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] r;
      apb(a, 1'b0, 32'h0, r);
      cmp32(r, e);
   endtask

   // Register write and its effect on the model
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      logic [31:0] r;
      apb(a, 1'b1, {16'h0000, d}, r);
      case (a)
         OFFS_CONTROL_ONE: exp1 = d & CONTROL_ONE_MASK;
         OFFS_CONTROL_TWO: exp2 = d & 16'hFFFC;
         OFFS_IRQ_ENABLE: expEn = d[1:0];
         OFFS_IRQ_CLEAR: expSt = expSt & ~d[1:0];
         default: ;
      endcase
   endtask

   // Model of one edge event reaching the unit
   task automatic model(int e);
      if (exp1[15] && exp1[11] && !(idleMode && exp1[13]) && !(e == 1 && exp1[10] && !exp2[8])
         && !exp2[8 + e]) begin
         exp2[8 + e] = 1'b1;
         expSt[e] = 1'b1;
         if (e == 1 && exp1[8]) trigExp++;
      end
   endtask

   task automatic checkAll();
      rd(OFFS_CONTROL_TWO, {16'h0000, exp2});
      rd(OFFS_IRQ_STATUS, {30'h0, expSt});
      cmp1(currentOn, exp1[15] && exp1[11] && exp2[8] && !exp2[9]);
      cmp1(irq, |(expSt & expEn));
   endtask

   // Rise then fall of one source, checked after each change
   task automatic pulse(int e, int b, bit pos);
      lvl[b] <= 1'b1;
      repeat (8) @(posedge ref_clk);
      if (pos) model(e);
      checkAll();
      lvl[b] <= 1'b0;
      repeat (8) @(posedge ref_clk);
      if (!pos) model(e);
      checkAll();
   endtask

   initial begin
      bit [31:0] rv;
      int srcPin[4] = '{0, 1, 5, 4};
      repeat (5) @(posedge ref_clk);
      rst_n <= 1'b1;
      for (int a = 0; a <= 20; a += 4) rd(a[7:0], 32'h0);
      $display("test reset values done");
      wr(OFFS_CONTROL_TWO, 16'h3C3C);
      for (int i = 0; i < 8; i++) begin
         rv = $random(seed);
         wr(OFFS_CONTROL_ONE, rv[15:0]);
         rd(OFFS_CONTROL_ONE, {16'h0000, exp1});
      end
      wr(OFFS_CONTROL_ONE, 16'h0000);
      $display("test control one done");
      wr(OFFS_CONTROL_TWO, 16'hC0C0);
      wr(OFFS_IRQ_ENABLE, 16'h0003);
      wr(OFFS_CONTROL_ONE, 16'h8D00);
      pulse(1, 2, 1'b1);
      pulse(0, 0, 1'b1);
      pulse(1, 2, 1'b1);
      cmp32(trigCnt, trigExp);
      wr(OFFS_IRQ_CLEAR, 16'h0003);
      checkAll();
      wr(OFFS_CONTROL_TWO, 16'hC0C0);
      wr(OFFS_IRQ_ENABLE, 16'h0000);
      pulse(0, 0, 1'b1);
      wr(OFFS_IRQ_ENABLE, 16'h0001);
      checkAll();
      $display("test edge sequence done");
      wr(OFFS_CONTROL_TWO, 16'hC0C0);
      wr(OFFS_CONTROL_ONE, 16'h8200);
      pulse(0, 0, 1'b1);
      cmp1(sourceGroundOut, 1'b1);
      wr(OFFS_CONTROL_ONE, 16'hA800);
      idleMode <= 1'b1;
      pulse(0, 0, 1'b1);
      idleMode <= 1'b0;
      pulse(0, 0, 1'b1);
      $display("test gate and idle done");
      for (int k = 0; k < 4; k++) begin
         wr(OFFS_CONTROL_TWO, 16'h803C | 16'(k << 10));
         pulse(0, srcPin[k], 1'b0);
      end
      cmp32(trigCnt, trigExp);
      $display("test sources done");
      wr(OFFS_CONTROL_TWO, 16'h403C);
      pulse(0, 0, 1'b1);
      wr(OFFS_CONTROL_TWO, 16'hCD3C);
      for (int j = 0; j < 2; j++) begin
         wr(OFFS_CONTROL_ONE, (j == 0) ? 16'h9800 : 16'h8800);
         checkAll();
         cmp1(delayPulse, exp1[12] && exp1[15] && exp1[11] && exp2[8] && !exp2[9]);
      end
      $display("test level and delay done");
      closeOut();
   end
endmodule

// File: test/edge_source_model.sv
// Model of the external edge sources that feed the charge time unit
`timescale 1ns/1ps
// ==========================================
// Edge source model
module edge_source_model (
   input wire logic ref_clk,
   input wire logic [5:0] lvl,
   output logic timerEvent,
   output logic compareOut,
   output logic captureEvent,
   output logic comparatorOut,
   output logic edge_pin_a,
   output logic edge_pin_b
);
   logic [5:0] srcQ = 6'h00;

   // Sources change just after the clock edge, like on-chip peripherals
   always_ff @(posedge ref_clk) begin
      srcQ <= lvl;
   end

   // Two sources per edge on chip, plus both edge pins
   assign {edge_pin_b, edge_pin_a, comparatorOut, captureEvent, compareOut, timerEvent} = srcQ;
endmodule

// File: verilog/charge_time_edge_control.sv
// Digital control of the charge time measurement unit with APB register access
//
// The register offsets and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps

module charge_time_edge_control (
   input wire logic ref_clk,
   input wire logic rst_n,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Device state and edge sources
   input wire logic idleMode,
   input wire logic timerEvent,
   input wire logic compareOut,
   input wire logic captureEvent,
   input wire logic comparatorOut,
   input wire logic edge_pin_a,
   input wire logic edge_pin_b,
   // Analog and trigger controls, and the interrupt request
   output logic currentOn,
   output logic sourceGroundOut,
   output logic delayPulse,
   output logic triggerPulse,
   output logic irq
);
   import charge_time_pkg::*;

   // ==========================================
   // Pin synchronisers
   logic [1:0] pinA_q;
   logic [1:0] pinB_q;
   logic [1:0] pinA_d;
   logic [1:0] pinB_d;

   // Two flip-flops per pin before any logic looks at it
   always_comb begin
      pinA_d = {pinA_q[0], edge_pin_a};
      pinB_d = {pinB_q[0], edge_pin_b};
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         pinA_q <= 2'b00;
         pinB_q <= 2'b00;
      end else begin
         pinA_q <= pinA_d;
         pinB_q <= pinB_d;
      end
   end

   // ==========================================
   // APB decode
   function automatic logic regHit(input logic [7:0] addr, input logic [7:0] offs);
      regHit = (addr == offs);
   endfunction

   logic setupPhase;
   logic wrAccess;
   logic mapped;
   logic wrOne;
   logic wrTwo;
   logic wrEnable;
   logic wrClear;

   // Zero-wait slave: writes take effect in the access phase
   always_comb begin
      setupPhase = psel & ~penable;
      wrAccess = psel & penable & pwrite;
      mapped = 1'b0;
      if (regHit(paddr, OFFS_CONTROL_ONE)) begin
         mapped = 1'b1;
      end else if (regHit(paddr, OFFS_CONTROL_TWO)) begin
         mapped = 1'b1;
      end else if (regHit(paddr, OFFS_IRQ_STATUS)) begin
         mapped = 1'b1;
      end else if (regHit(paddr, OFFS_IRQ_ENABLE)) begin
         mapped = 1'b1;
      end else if (regHit(paddr, OFFS_IRQ_CLEAR)) begin
         mapped = 1'b1;
      end
      wrOne = wrAccess & regHit(paddr, OFFS_CONTROL_ONE);
      wrTwo = wrAccess & regHit(paddr, OFFS_CONTROL_TWO);
      wrEnable = wrAccess & regHit(paddr, OFFS_IRQ_ENABLE);
      wrClear = wrAccess & regHit(paddr, OFFS_IRQ_CLEAR);
   end

   assign pready = 1'b1;
   assign pslverr = psel & penable & ~mapped;

   // ==========================================
   // Control registers
   logic [15:0] ctrlOne_q;
   logic [15:0] ctrlOne_d;
   logic [15:0] ctrlTwo_q;
   logic [15:0] ctrlTwo_d;
   control_one_t ctl;
   edge_cfg_t firstCfg;
   edge_cfg_t secondCfg;
   logic firstFlag_q;
   logic firstFlag_d;
   logic secondFlag_q;
   logic secondFlag_d;
   logic unitActive;
   logic firstHit;
   logic secondHit;
   logic firstSet;
   logic secondSet;

   // Only implemented bits are stored so unimplemented ones read zero
   always_comb begin
      ctrlOne_d = ctrlOne_q;
      ctrlTwo_d = ctrlTwo_q;
      if (wrOne) begin
         ctrlOne_d = pwdata[15:0] & CONTROL_ONE_MASK;
      end
      if (wrTwo) begin
         ctrlTwo_d = {pwdata[15:10], 2'b00, pwdata[7:2], 2'b00};
      end
   end

   always_comb begin
      ctl.unitEnable = ctrlOne_q[BIT_UNIT_ENABLE];
      ctl.idleStop = ctrlOne_q[BIT_IDLE_STOP];
      ctl.delayGen = ctrlOne_q[BIT_DELAY_GEN];
      ctl.edgeGate = ctrlOne_q[BIT_EDGE_GATE];
      ctl.edgeOrder = ctrlOne_q[BIT_EDGE_ORDER];
      ctl.sourceGround = ctrlOne_q[BIT_SOURCE_GROUND];
      ctl.triggerOut = ctrlOne_q[BIT_TRIGGER_OUT];
      firstCfg.sampling = ctrlTwo_q[BIT_FIRST_SAMPLING];
      firstCfg.polarity = ctrlTwo_q[BIT_FIRST_POLARITY];
      firstCfg.source = ctrlTwo_q[LSB_FIRST_SOURCE+:4];
      secondCfg.sampling = ctrlTwo_q[BIT_SECOND_SAMPLING];
      secondCfg.polarity = ctrlTwo_q[BIT_SECOND_POLARITY];
      secondCfg.source = ctrlTwo_q[LSB_SECOND_SOURCE+:4];
   end

   // Unit runs when enabled and not stopped by Idle mode
   always_comb begin
      unitActive = ctl.unitEnable & ~(ctl.idleStop & idleMode);
   end

   // ==========================================
   // Edge sensors, four sources each
   edge_sense firstSense (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .srcIn({pinA_q[1], pinB_q[1], compareOut, timerEvent}),
      .cfg(firstCfg),
      .hit(firstHit)
   );

   edge_sense secondSense (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .srcIn({pinB_q[1], pinA_q[1], comparatorOut, captureEvent}),
      .cfg(secondCfg),
      .hit(secondHit)
   );

   // ==========================================
   // Edge flags: hardware set wins over a software write of zero
   always_comb begin
      firstSet = unitActive & ctl.edgeGate & firstHit & ~firstFlag_q;
      secondSet = unitActive & ctl.edgeGate & secondHit & ~secondFlag_q
         & (~ctl.edgeOrder | firstFlag_q);
      firstFlag_d = wrTwo ? pwdata[BIT_FIRST_FLAG] : firstFlag_q;
      secondFlag_d = wrTwo ? pwdata[BIT_SECOND_FLAG] : secondFlag_q;
      if (firstSet) begin
         firstFlag_d = 1'b1;
      end
      if (secondSet) begin
         secondFlag_d = 1'b1;
      end
   end

   // ==========================================
   // Analog and trigger outputs
   logic currentOn_d;
   logic ground_d;
   logic delay_d;
   logic trig_d;
   logic currentOn_q;
   logic ground_q;
   logic delay_q;
   logic trig_q;

   always_comb begin
      currentOn_d = unitActive & ctl.edgeGate & firstFlag_d & ~secondFlag_d;
      ground_d = ctl.unitEnable & ctl.sourceGround;
      delay_d = ctl.delayGen & currentOn_d;
      trig_d = ctl.triggerOut & unitActive & secondSet;
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         ctrlOne_q <= CONTROL_ONE_RESET;
         ctrlTwo_q <= CONTROL_TWO_RESET;
         firstFlag_q <= 1'b0;
         secondFlag_q <= 1'b0;
         currentOn_q <= 1'b0;
         ground_q <= 1'b0;
         delay_q <= 1'b0;
         trig_q <= 1'b0;
      end else begin
         ctrlOne_q <= ctrlOne_d;
         ctrlTwo_q <= ctrlTwo_d;
         firstFlag_q <= firstFlag_d;
         secondFlag_q <= secondFlag_d;
         currentOn_q <= currentOn_d;
         ground_q <= ground_d;
         delay_q <= delay_d;
         trig_q <= trig_d;
      end
   end

   assign currentOn = currentOn_q;
   assign sourceGroundOut = ground_q;
   assign delayPulse = delay_q;
   assign triggerPulse = trig_q;

   // ==========================================
   // Interrupts
   logic [IRQ_COUNT-1:0] irqStatus;
   logic [IRQ_COUNT-1:0] irqEnable;
   logic [IRQ_COUNT-1:0] irqEvents;

   always_comb begin
      irqEvents = '0;
      irqEvents[IRQ_FIRST_EDGE] = firstSet;
      irqEvents[IRQ_SECOND_EDGE] = secondSet;
   end

   irq_block #(
      .N(IRQ_COUNT)
   ) irqUnit (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .event_in(irqEvents),
      .enableWr(wrEnable),
      .clearWr(wrClear),
      .wrData(pwdata[IRQ_COUNT-1:0]),
      .status(irqStatus),
      .enable(irqEnable),
      .irq(irq)
   );

   // ==========================================
   // Read data captured in the setup phase
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;

   always_comb begin
      rdata_d = rdata_q;
      if (setupPhase & ~pwrite) begin
         rdata_d = 32'h0000_0000;
         if (regHit(paddr, OFFS_CONTROL_ONE)) begin
            rdata_d[15:0] = ctrlOne_q;
         end else if (regHit(paddr, OFFS_CONTROL_TWO)) begin
            rdata_d[15:0] = ctrlTwo_q;
            rdata_d[BIT_FIRST_FLAG] = firstFlag_q;
            rdata_d[BIT_SECOND_FLAG] = secondFlag_q;
         end else if (regHit(paddr, OFFS_IRQ_STATUS)) begin
            rdata_d[IRQ_COUNT-1:0] = irqStatus;
         end else if (regHit(paddr, OFFS_IRQ_ENABLE)) begin
            rdata_d[IRQ_COUNT-1:0] = irqEnable;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         rdata_q <= 32'h0000_0000;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign prdata = rdata_q;

endmodule

// File: verilog/charge_time_pkg.sv
// Package with register map, field positions and carrier types of the charge time unit
package charge_time_pkg;

   // ==========================================
   // Register byte offsets on the APB
   localparam logic [7:0] OFFS_CONTROL_ONE = 8'h00;
   localparam logic [7:0] OFFS_CONTROL_TWO = 8'h04;
   localparam logic [7:0] OFFS_IRQ_STATUS = 8'h08;
   localparam logic [7:0] OFFS_IRQ_ENABLE = 8'h0C;
   localparam logic [7:0] OFFS_IRQ_CLEAR = 8'h10;

   // ==========================================
   // Control register one field positions
   localparam int BIT_UNIT_ENABLE = 15;
   localparam int BIT_IDLE_STOP = 13;
   localparam int BIT_DELAY_GEN = 12;
   localparam int BIT_EDGE_GATE = 11;
   localparam int BIT_EDGE_ORDER = 10;
   localparam int BIT_SOURCE_GROUND = 9;
   localparam int BIT_TRIGGER_OUT = 8;
   localparam logic [15:0] CONTROL_ONE_MASK = 16'hBF00;
   localparam logic [15:0] CONTROL_ONE_RESET = 16'h0000;

   // ==========================================
   // Control register two field positions
   localparam int BIT_FIRST_SAMPLING = 15;
   localparam int BIT_FIRST_POLARITY = 14;
   localparam int LSB_FIRST_SOURCE = 10;
   localparam int BIT_SECOND_FLAG = 9;
   localparam int BIT_FIRST_FLAG = 8;
   localparam int BIT_SECOND_SAMPLING = 7;
   localparam int BIT_SECOND_POLARITY = 6;
   localparam int LSB_SECOND_SOURCE = 2;
   localparam logic [15:0] CONTROL_TWO_RESET = 16'h0000;

   // ==========================================
   // Edge source select codes, first edge naming
   localparam logic [3:0] SRC_TIMER = 4'h0;
   localparam logic [3:0] SRC_COMPARE = 4'h1;
   localparam logic [3:0] SRC_OTHER_PIN = 4'h2;
   localparam logic [3:0] SRC_OWN_PIN = 4'h3;

   // ==========================================
   // Interrupt events
   localparam int IRQ_COUNT = 2;
   localparam int IRQ_FIRST_EDGE = 0;
   localparam int IRQ_SECOND_EDGE = 1;

   // Per-edge configuration carried to an edge sensor
   typedef struct packed {
      logic sampling;
      logic polarity;
      logic [3:0] source;
   } edge_cfg_t;

   // Control register one decoded
   typedef struct packed {
      logic unitEnable;
      logic idleStop;
      logic delayGen;
      logic edgeGate;
      logic edgeOrder;
      logic sourceGround;
      logic triggerOut;
   } control_one_t;

endpackage

// File: verilog/edge_sense.sv
// Edge sensor: source select, polarity and edge or level sampling for one edge input
`timescale 1ns/1ps
module edge_sense (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [3:0] srcIn,
   input charge_time_pkg::edge_cfg_t cfg,
   output logic hit
);
   import charge_time_pkg::*;

   logic prev_q;
   logic prev_d;
   logic selected;
   logic srcValid;

   // Select one of four sources; reserved codes select nothing
   always_comb begin
      selected = 1'b0;
      srcValid = (cfg.source[3:2] == 2'b00);
      if (srcValid) begin
         selected = srcIn[cfg.source[1:0]];
      end
      prev_d = selected;
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         prev_q <= 1'b0;
      end else begin
         prev_q <= prev_d;
      end
   end

   // Edge mode looks for the chosen transition, level mode for the chosen level
   // A reserved source never hits, even in negative level mode
   always_comb begin
      if (!srcValid) begin
         hit = 1'b0;
      end else if (cfg.sampling) begin
         hit = cfg.polarity ? (selected & ~prev_q) : (~selected & prev_q);
      end else begin
         hit = cfg.polarity ? selected : ~selected;
      end
   end

endmodule

// File: verilog/irq_block.sv
// Sticky interrupt status with enable and write-one-to-clear register
`timescale 1ns/1ps
module irq_block #(
   parameter int N = 2
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [N-1:0] event_in,
   input wire logic enableWr,
   input wire logic clearWr,
   input wire logic [N-1:0] wrData,
   output logic [N-1:0] status,
   output logic [N-1:0] enable,
   output logic irq
);
   logic [N-1:0] status_q;
   logic [N-1:0] status_d;
   logic [N-1:0] enable_q;
   logic [N-1:0] enable_d;
   logic irq_q;
   logic irq_d;

   // Set wins over a clear in the same cycle
   always_comb begin
      status_d = status_q;
      if (clearWr) begin
         status_d = status_q & ~wrData;
      end
      status_d = status_d | event_in;
      enable_d = enableWr ? wrData : enable_q;
      irq_d = |(status_d & enable_d);
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         status_q <= '0;
         enable_q <= '0;
         irq_q <= 1'b0;
      end else begin
         status_q <= status_d;
         enable_q <= enable_d;
         irq_q <= irq_d;
      end
   end

   assign status = status_q;
   assign enable = enable_q;
   assign irq = irq_q;

endmodule
